// >>> dtg_keypad_tone.v
// Keypad decoder and dual tone generator with register port
//
// Function
// - Keypad lines idle high, pulled low active.
// - Tone suppress low blocks every tone.
// - Key flag pulls low while key pressed.
// - Key flag ignores suppress and lone-tone inputs.
// - Lone-tone block low allows dual tones only.
// - One row plus one column gives dual.
// - One column, no row, gives column tone.
// - Several columns give no column tone.
// - Rows without column give no tone.
// - Two columns plus one row give row.
// - Key sets row and column divider ratios.
// - Stepped sines from ladder, mixed to output.
// - Rows one, two: 701.3 and 771.4 Hz.
// - Rows three, four: 857.2 and 935.1 Hz.
// - Columns one, two: 1215.9 and 1331.7 Hz.
// - Columns three, four: 1471.9 and 1645.0 Hz.
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "dtg_defs.vh"

module dtg_keypad_tone (
    input wire clk_sys,
    input wire rst_n,
    input wire [3:0] row_n,
    input wire [3:0] col_n,
    input wire tone_suppress_n,
    input wire lone_tone_allow,
    output reg key_flag_out_r,
    output reg key_flag_oe_r,
    output reg [8:0] tone_out_r,
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_r,
    output reg irq_r
);

    // Tone periods in reference ticks
    localparam [31:0] P_ROW1 = `DTG_PERIOD(`DTG_ROW1_DHZ);
    localparam [31:0] P_ROW2 = `DTG_PERIOD(`DTG_ROW2_DHZ);
    localparam [31:0] P_ROW3 = `DTG_PERIOD(`DTG_ROW3_DHZ);
    localparam [31:0] P_ROW4 = `DTG_PERIOD(`DTG_ROW4_DHZ);
    localparam [31:0] P_COL1 = `DTG_PERIOD(`DTG_COL1_DHZ);
    localparam [31:0] P_COL2 = `DTG_PERIOD(`DTG_COL2_DHZ);
    localparam [31:0] P_COL3 = `DTG_PERIOD(`DTG_COL3_DHZ);
    localparam [31:0] P_COL4 = `DTG_PERIOD(`DTG_COL4_DHZ);
    localparam [31:0] CTRL_RST = `DTG_CTRL_RST;

    // Selection states
    localparam [1:0] SEL_NONE = 2'b00;
    localparam [1:0] SEL_DUAL = 2'b01;
    localparam [1:0] SEL_COL = 2'b10;
    localparam [1:0] SEL_ROW = 2'b11;

    reg [7:0] line_meta_r;
    reg [7:0] line_sync_r;
    reg [31:0] ref_acc_r;
    reg ref_tick_r;
    reg [1:0] sel_r;
    reg [1:0] sel_nxt;
    reg [1:0] row_idx_r;
    reg [1:0] row_idx_nxt;
    reg [1:0] col_idx_r;
    reg [1:0] col_idx_nxt;
    reg [12:0] row_period;
    reg [12:0] col_period;
    reg any_key_r;
    reg ctrl_tone_en_r;
    reg [`DTG_EV_W-1:0] stat_r;
    reg [`DTG_EV_W-1:0] stat_nxt;
    reg [`DTG_EV_W-1:0] mask_r;
    reg [`DTG_EV_W-1:0] ev;
    reg [2:0] row_cnt;
    reg [2:0] col_cnt;
    integer i;

    wire [3:0] row_act;
    wire [3:0] col_act;
    wire any_key;
    wire sel_change;
    wire row_run;
    wire col_run;
    wire [3:0] row_step;
    wire [3:0] col_step;
    wire [7:0] row_sample;
    wire [7:0] col_sample;
    wire [32:0] ref_sum;

    // two-flop sync of all eight lines
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            line_meta_r <= 8'hFF;
            line_sync_r <= 8'hFF;
        end else begin
            line_meta_r <= {col_n, row_n};
            line_sync_r <= line_meta_r;
        end
    end

    assign row_act = ~line_sync_r[3:0];
    assign col_act = ~line_sync_r[7:4];
    assign any_key = (|row_act) | (|col_act);

    // Count asserted rows and columns
    always @* begin
        row_cnt = 3'd0;
        col_cnt = 3'd0;
        for (i = 0; i < 4; i = i + 1) begin
            row_cnt = row_cnt + {2'b00, row_act[i]};
            col_cnt = col_cnt + {2'b00, col_act[i]};
        end
    end

    // Encode the lowest asserted line of each group
    always @* begin
        row_idx_nxt = 2'd0;
        col_idx_nxt = 2'd0;
        for (i = 3; i >= 0; i = i - 1) begin
            if (row_act[i]) begin
                row_idx_nxt = i[1:0];
            end
            if (col_act[i]) begin
                col_idx_nxt = i[1:0];
            end
        end
    end

    // Pick the tones the key pattern asks for
    always @* begin
        sel_nxt = SEL_NONE;
        // a column is needed for any tone
        if (col_cnt == 3'd0) begin
            sel_nxt = SEL_NONE;
        end else if (col_cnt == 3'd1 && row_cnt == 3'd1) begin
            sel_nxt = SEL_DUAL;
        // one column with no row, or two or more keys in one column
        end else if (col_cnt == 3'd1) begin
            sel_nxt = SEL_COL;
        // two columns and one row give that row alone
        end else if (col_cnt == 3'd2 && row_cnt == 3'd1) begin
            sel_nxt = SEL_ROW;
        end else begin
            sel_nxt = SEL_NONE;
        end
        // single tones need the allow input high
        if (!lone_tone_allow && sel_nxt != SEL_DUAL) begin
            sel_nxt = SEL_NONE;
        end
        if (!tone_suppress_n || !ctrl_tone_en_r) begin
            sel_nxt = SEL_NONE;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            sel_r <= SEL_NONE;
            row_idx_r <= 2'd0;
            col_idx_r <= 2'd0;
            any_key_r <= 1'b0;
        end else begin
            sel_r <= sel_nxt;
            row_idx_r <= row_idx_nxt;
            col_idx_r <= col_idx_nxt;
            any_key_r <= any_key;
        end
    end

    // A new pattern holds the generators for one cycle so each restarts in phase
    assign sel_change = (sel_nxt != sel_r) || (row_idx_nxt != row_idx_r)
                        || (col_idx_nxt != col_idx_r);

    // generators run only for an active selection
    assign row_run = (sel_r == SEL_DUAL || sel_r == SEL_ROW) && !sel_change;
    assign col_run = (sel_r == SEL_DUAL || sel_r == SEL_COL) && !sel_change;

    // flag drives low while any line is asserted; no gating
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            key_flag_out_r <= 1'b0;
            key_flag_oe_r <= 1'b0;
        end else begin
            key_flag_out_r <= 1'b0;
            key_flag_oe_r <= any_key;
        end
    end

    // Reference tick at the crystal rate, spread evenly over the system clock
    assign ref_sum = {1'b0, ref_acc_r} + {1'b0, `DTG_REF_HZ};

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            ref_acc_r <= 32'h00000000;
            ref_tick_r <= 1'b0;
        end else if (ref_sum >= {1'b0, `DTG_CLK_HZ}) begin
            ref_acc_r <= ref_sum[31:0] - `DTG_CLK_HZ;
            ref_tick_r <= 1'b1;
        end else begin
            ref_acc_r <= ref_sum[31:0];
            ref_tick_r <= 1'b0;
        end
    end

    // decoded key selects the divider ratios
    always @* begin
        case (row_idx_r)
            2'd0: row_period = P_ROW1[12:0];
            2'd1: row_period = P_ROW2[12:0];
            2'd2: row_period = P_ROW3[12:0];
            default: row_period = P_ROW4[12:0];
        endcase
        case (col_idx_r)
            2'd0: col_period = P_COL1[12:0];
            2'd1: col_period = P_COL2[12:0];
            2'd2: col_period = P_COL3[12:0];
            default: col_period = P_COL4[12:0];
        endcase
    end

    dtg_tone_gen u_row_gen (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ref_tick(ref_tick_r),
        .run(row_run),
        .period(row_period),
        .step_r(row_step)
    );

    dtg_tone_gen u_col_gen (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ref_tick(ref_tick_r),
        .run(col_run),
        .period(col_period),
        .step_r(col_step)
    );

    dtg_sine_rom u_row_rom (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .en(row_run),
        .idx(row_step),
        .data_r(row_sample)
    );

    dtg_sine_rom u_col_rom (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .en(col_run),
        .idx(col_step),
        .data_r(col_sample)
    );

    // mix both groups; an idle group adds midscale
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            tone_out_r <= `DTG_OUT_MID;
        end else begin
            tone_out_r <= {1'b0, row_sample} + {1'b0, col_sample};
        end
    end

    // Events: press, release, tone start, tone lost while a key stays pressed
    always @* begin
        ev = {`DTG_EV_W{1'b0}};
        ev[`DTG_EV_PRESS] = any_key && !any_key_r;
        ev[`DTG_EV_RELEASE] = !any_key && any_key_r;
        ev[`DTG_EV_TONE] = (sel_nxt != SEL_NONE) && (sel_r == SEL_NONE);
        ev[`DTG_EV_BAD] = (sel_nxt == SEL_NONE) && (sel_r != SEL_NONE) && any_key;
    end

    // Write one clears; a new event in the same cycle wins
    always @* begin
        stat_nxt = stat_r;
        if (reg_wr && reg_addr == `DTG_OFS_STAT) begin
            stat_nxt = stat_r & ~reg_wdata[`DTG_EV_W-1:0];
        end
        stat_nxt = stat_nxt | ev;
    end

    // Register writes
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_tone_en_r <= CTRL_RST[`DTG_CTRL_TONE_EN];
            mask_r <= {`DTG_EV_W{1'b0}};
            stat_r <= {`DTG_EV_W{1'b0}};
        end else begin
            stat_r <= stat_nxt;
            if (reg_wr) begin
                if (reg_addr == `DTG_OFS_CTRL) begin
                    ctrl_tone_en_r <= reg_wdata[`DTG_CTRL_TONE_EN];
                end else if (reg_addr == `DTG_OFS_MASK) begin
                    mask_r <= reg_wdata[`DTG_EV_W-1:0];
                end
            end
        end
    end

    // Read data stand only in the cycle after the strobe; unmapped reads zero
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata_r <= 32'h00000000;
        end else if (reg_rd) begin
            if (reg_addr == `DTG_OFS_CTRL) begin
                reg_rdata_r <= {31'h00000000, ctrl_tone_en_r};
            end else if (reg_addr == `DTG_OFS_STAT) begin
                reg_rdata_r <= {28'h0000000, stat_r};
            end else if (reg_addr == `DTG_OFS_MASK) begin
                reg_rdata_r <= {28'h0000000, mask_r};
            end else if (reg_addr == `DTG_OFS_KEYS) begin
                reg_rdata_r <= {16'h0000, 2'b00, sel_r, col_idx_r, row_idx_r,
                                col_act, row_act};
            end else begin
                reg_rdata_r <= 32'h00000000;
            end
        end else begin
            reg_rdata_r <= 32'h00000000;
        end
    end

    // Level interrupt while any unmasked status bit is set
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(stat_nxt & mask_r);
        end
    end

endmodule // dtg_keypad_tone
`default_nettype wire

// >>> dtg_defs.vh
// Shared constants of the keypad tone generator
`ifndef DTG_DEFS_VH
`define DTG_DEFS_VH

// System clock and tone reference rate, in Hz
`define DTG_CLK_HZ 32'd25000000
`define DTG_REF_HZ 32'd3579545

// Produced tone frequencies, in tenths of a hertz
`define DTG_ROW1_DHZ 32'd7013
`define DTG_ROW2_DHZ 32'd7714
`define DTG_ROW3_DHZ 32'd8572
`define DTG_ROW4_DHZ 32'd9351
`define DTG_COL1_DHZ 32'd12159
`define DTG_COL2_DHZ 32'd13317
`define DTG_COL3_DHZ 32'd14719
`define DTG_COL4_DHZ 32'd16450

// Tone period in reference ticks, rounded to nearest
`define DTG_PERIOD(dhz) ((`DTG_REF_HZ * 32'd10 + (dhz) / 32'd2) / (dhz))

// Staircase codes
`define DTG_SINE_MID 8'h80
`define DTG_OUT_MID 9'h100

// Register byte offsets
`define DTG_OFS_CTRL 4'h0
`define DTG_OFS_STAT 4'h4
`define DTG_OFS_MASK 4'h8
`define DTG_OFS_KEYS 4'hC

// Control fields and reset value
`define DTG_CTRL_TONE_EN 0
`define DTG_CTRL_RST 32'h00000001

// Event bits, shared by status and mask
`define DTG_EV_PRESS 0
`define DTG_EV_RELEASE 1
`define DTG_EV_TONE 2
`define DTG_EV_BAD 3
`define DTG_EV_W 4

`endif

// >>> dtg_sine_rom.v
// Sixteen-step sine table with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "dtg_defs.vh"

module dtg_sine_rom (
    input wire clk_sys,
    input wire rst_n,
    input wire en,
    input wire [3:0] idx,
    output reg [7:0] data_r
);

    reg [7:0] sine_nxt;

    always @* begin
        case (idx)
            4'h0: sine_nxt = 8'h80;
            4'h1: sine_nxt = 8'hB1;
            4'h2: sine_nxt = 8'hDA;
            4'h3: sine_nxt = 8'hF5;
            4'h4: sine_nxt = 8'hFF;
            4'h5: sine_nxt = 8'hF5;
            4'h6: sine_nxt = 8'hDA;
            4'h7: sine_nxt = 8'hB1;
            4'h8: sine_nxt = 8'h80;
            4'h9: sine_nxt = 8'h4F;
            4'hA: sine_nxt = 8'h26;
            4'hB: sine_nxt = 8'h0B;
            4'hC: sine_nxt = 8'h01;
            4'hD: sine_nxt = 8'h0B;
            4'hE: sine_nxt = 8'h26;
            default: sine_nxt = 8'h4F;
        endcase
    end

    // Idle generator parks at midscale
    always @(posedge clk_sys) begin
        if (!rst_n || !en) begin
            data_r <= `DTG_SINE_MID;
        end else begin
            data_r <= sine_nxt;
        end
    end

endmodule // dtg_sine_rom
`default_nettype wire

// >>> dtg_tone_gen.v
// Programmable divider stepping one staircase sine
`timescale 1ns/10ps
`default_nettype none

module dtg_tone_gen (
    input wire clk_sys,
    input wire rst_n,
    input wire ref_tick,
    input wire run,
    input wire [12:0] period,
    output reg [3:0] step_r
);

    reg [8:0] cnt_r;
    wire [8:0] base;
    wire [8:0] last;

    // Period spread over 16 steps; the first period[3:0] steps get one extra tick
    assign base = period[12:4];
    assign last = (step_r < period[3:0]) ? base : base - 9'h001;

    always @(posedge clk_sys) begin
        if (!rst_n || !run) begin
            cnt_r <= 9'h000;
            step_r <= 4'h0;
        end else if (ref_tick) begin
            if (cnt_r >= last) begin
                cnt_r <= 9'h000;
                step_r <= step_r + 4'h1;
            end else begin
                cnt_r <= cnt_r + 9'h001;
            end
        end
    end

endmodule // dtg_tone_gen
`default_nettype wire

// >>> dtg_keypad_tone_checker.sv
// Port checker for the keypad tone generator
`timescale 1ns/10ps
`default_nettype none
`include "dtg_defs.vh"
module dtg_keypad_tone_checker (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [3:0] row_n,
    input wire logic [3:0] col_n,
    input wire logic tone_suppress_n,
    input wire logic lone_tone_allow,
    input wire logic key_flag_out_r,
    input wire logic key_flag_oe_r,
    input wire logic [8:0] tone_out_r,
    input wire logic reg_rd,
    input wire logic irq_r
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire logic any_act = ~&{row_n, col_n};
    wire logic one_row = $countones(~row_n) == 1;
    wire logic one_col = $countones(~col_n) == 1;
    wire logic many_col = $countones(~col_n) > 2;
    // Patterns that can only give a lone tone
    wire logic lone_pat = (one_col && !one_row) || ($countones(~col_n) == 2 && one_row);
    property p_flag_low; key_flag_out_r == 1'b0; endproperty
    a_flag_low: assert property (p_flag_low) else $error("flag pin driven high");
    property p_flag_on; any_act [*3] |=> key_flag_oe_r; endproperty
    a_flag_on: assert property (p_flag_on) else $error("flag not pulled");
    property p_flag_off; !any_act [*3] |=> !key_flag_oe_r; endproperty
    a_flag_off: assert property (p_flag_off) else $error("flag left pulled");
    property p_sync; !any_act [*3] ##1 any_act |=> !key_flag_oe_r [*2]; endproperty
    a_sync: assert property (p_sync) else $error("flag ahead of sync");
    property p_no_col; (&col_n) [*8] |=> tone_out_r == `DTG_OUT_MID; endproperty
    a_no_col: assert property (p_no_col) else $error("tone without column");
    property p_supp; !tone_suppress_n [*8] |=> tone_out_r == `DTG_OUT_MID; endproperty
    a_supp: assert property (p_supp) else $error("tone while suppressed");
    property p_many_col; many_col [*8] |=> tone_out_r == `DTG_OUT_MID; endproperty
    a_many_col: assert property (p_many_col) else $error("tone on many columns");
    property p_dual_only;
        (!lone_tone_allow && lone_pat) [*8] |=> tone_out_r == `DTG_OUT_MID;
    endproperty
    a_dual_only: assert property (p_dual_only) else $error("lone tone not blocked");
    c_dual: cover property (key_flag_oe_r && tone_out_r != `DTG_OUT_MID);
    c_irq: cover property ($rose(irq_r));
    c_read: cover property (reg_rd);
endmodule // dtg_keypad_tone_checker
`default_nettype wire

// >>> dtg_keypad_model.sv
// Keypad model driving the row and column lines
`timescale 1ns/10ps
`default_nettype none
module dtg_keypad_model (
    input wire logic clk_sys,
    input wire logic [7:0] keys,
    output var logic [3:0] row_n,
    output var logic [3:0] col_n
);
    initial begin
        row_n = 4'hF;
        col_n = 4'hF;
    end
    always @(posedge clk_sys) begin
        row_n <= ~keys[3:0];
        col_n <= ~keys[7:4];
    end
endmodule // dtg_keypad_model
`default_nettype wire

// >>> dtg_keypad_tone_tb_top.sv
// Self-checking bench for the keypad tone generator
`timescale 1ns/10ps
`default_nettype none
`include "dtg_defs.vh"
module dtg_keypad_tone_tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] keys = 8'h00;
    logic tone_suppress_n = 1'b1;
    logic lone_tone_allow = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire [3:0] row_n;
    wire [3:0] col_n;
    wire key_flag_out_r;
    wire key_flag_oe_r;
    wire irq_r;
    wire [8:0] tone_out_r;
    wire [31:0] reg_rdata_r;
    // Open-drain pin with its pull-up
    wire logic key_pin = key_flag_oe_r ? key_flag_out_r : 1'b1;
    integer errors = 0;
    integer comparisons = 0;
    integer seed = 88;
    integer i;
    logic [31:0] d;
    logic [3:0] r;
    logic [3:0] c;
    logic [1:0] s;
    initial forever #20 clk_sys = ~clk_sys;
    dtg_keypad_model u_dtg_keypad_model (.clk_sys(clk_sys), .keys(keys), .row_n(row_n),
        .col_n(col_n));
    dtg_keypad_tone u_dtg_keypad_tone (.clk_sys(clk_sys), .rst_n(rst_n), .row_n(row_n),
        .col_n(col_n), .tone_suppress_n(tone_suppress_n), .lone_tone_allow(lone_tone_allow),
        .key_flag_out_r(key_flag_out_r), .key_flag_oe_r(key_flag_oe_r),
        .tone_out_r(tone_out_r), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .irq_r(irq_r));
    task cyc(input integer n);
        repeat (n) @(posedge clk_sys);
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata_r;
    endtask
    task press(input logic [7:0] k);
        @(posedge clk_sys);
        keys <= k;
    endtask
    // Selection as a keypad sees it: 0 none, 1 dual, 2 column, 3 row
    function automatic logic [1:0] exp_sel(input logic [3:0] rr, input logic [3:0] cc,
        input logic a);
        integer nr;
        integer nc;
        nr = $countones(rr);
        nc = $countones(cc);
        if (nc == 1 && nr == 1) exp_sel = 2'd1;
        else if (a && nc == 1) exp_sel = 2'd2;
        else if (a && nc == 2 && nr == 1) exp_sel = 2'd3;
        else exp_sel = 2'd0;
    endfunction
    function automatic logic [1:0] idx(input logic [3:0] v);
        idx = v[1] ? 2'd1 : v[2] ? 2'd2 : v[3] ? 2'd3 : 2'd0;
    endfunction
    // Long hold so even the slowest row has left its first step
    task tone_case(input logic [7:0] k, input logic a, input logic sp, input logic en,
        input logic on);
        wr(`DTG_OFS_CTRL, {31'h0, en});
        tone_suppress_n <= sp;
        lone_tone_allow <= a;
        press(k);
        cyc(2600);
        chk(tone_out_r !== `DTG_OUT_MID, on, "tone");
        chk(key_pin, 1'b0, "flag");
        press(8'h00);
        cyc(12);
        chk(tone_out_r, `DTG_OUT_MID, "park");
    endtask
    // One whole period, peak step to peak step, of a lone tone
    task freq_case(input logic [7:0] k, input integer dhz);
        integer n;
        integer want;
        n = 0;
        want = (`DTG_CLK_HZ * 10 + dhz / 2) / dhz;
        wr(`DTG_OFS_CTRL, 32'h1);
        tone_suppress_n <= 1'b1;
        lone_tone_allow <= 1'b1;
        press(k);
        while (tone_out_r !== 9'h17F) @(posedge clk_sys);
        while (tone_out_r === 9'h17F) begin
            @(posedge clk_sys);
            n = n + 1;
        end
        while (tone_out_r !== 9'h17F) begin
            @(posedge clk_sys);
            n = n + 1;
        end
        chk(n > want - 3 && n < want + 3, 1'b1, "period");
        press(8'h00);
        cyc(12);
    endtask
    task end_sim;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        cyc(90000);
        errors = errors + 1;
        end_sim;
    end
    initial begin
        cyc(16);
        rst_n <= 1'b1;
        rd(`DTG_OFS_CTRL);
        chk(d, `DTG_CTRL_RST, "ctrl");
        rd(`DTG_OFS_MASK);
        chk(d, 32'h0, "mask");
        rd(4'h2);
        chk(d, 32'h0, "unmapped");
        wr(`DTG_OFS_MASK, 32'h1);
        press(8'h11);
        cyc(10);
        chk(irq_r, 1'b1, "irq");
        press(8'h00);
        cyc(10);
        rd(`DTG_OFS_STAT);
        chk(d, 32'h7, "stat");
        wr(`DTG_OFS_STAT, 32'hF);
        cyc(2);
        chk(irq_r, 1'b0, "irq clear");
        wr(`DTG_OFS_MASK, 32'h0);
        press(8'h11);
        cyc(10);
        chk(irq_r, 1'b0, "irq masked");
        press(8'h00);
        cyc(10);
        $display("test registers done");
        for (i = 0; i < 32; i = i + 1) begin
            d = $random(seed);
            r = d[3:0];
            c = d[7:4];
            if (i[0]) r = 4'h1 << r[1:0];
            if (i[1]) c = 4'h1 << c[1:0];
            lone_tone_allow <= i[2];
            press({c, r});
            cyc(8);
            rd(`DTG_OFS_KEYS);
            s = exp_sel(r, c, i[2]);
            chk(d[7:0], {c, r}, "lines");
            chk(d[13:12], s, "select");
            if (s == 2'd1 || s == 2'd3) chk(d[9:8], idx(r), "row index");
            if (s == 2'd1 || s == 2'd2) chk(d[11:10], idx(c), "col index");
            chk(key_pin, ~|{c, r}, "flag");
            if (s == 2'd0) chk(tone_out_r, `DTG_OUT_MID, "no tone");
        end
        press(8'h00);
        cyc(10);
        $display("test decode done");
        tone_case(8'h11, 1'b0, 1'b1, 1'b1, 1'b1);
        tone_case(8'h80, 1'b1, 1'b1, 1'b1, 1'b1);
        tone_case(8'h80, 1'b0, 1'b1, 1'b1, 1'b0);
        tone_case(8'h32, 1'b1, 1'b1, 1'b1, 1'b1);
        tone_case(8'h32, 1'b0, 1'b1, 1'b1, 1'b0);
        tone_case(8'h0F, 1'b1, 1'b1, 1'b1, 1'b0);
        tone_case(8'h84, 1'b1, 1'b0, 1'b1, 1'b0);
        tone_case(8'h48, 1'b1, 1'b1, 1'b0, 1'b0);
        $display("test tones done");
        freq_case(8'h38, `DTG_ROW4_DHZ);
        freq_case(8'h80, `DTG_COL4_DHZ);
        $display("test frequency done");
        end_sim;
    end
endmodule // dtg_keypad_tone_tb_top
bind dtg_keypad_tone dtg_keypad_tone_checker u_dtg_keypad_tone_checker (.clk_sys(clk_sys),
    .rst_n(rst_n), .row_n(row_n), .col_n(col_n), .tone_suppress_n(tone_suppress_n),
    .lone_tone_allow(lone_tone_allow), .key_flag_out_r(key_flag_out_r),
    .key_flag_oe_r(key_flag_oe_r), .tone_out_r(tone_out_r), .reg_rd(reg_rd), .irq_r(irq_r));
`default_nettype wire
